// >>> verilog/tdq_cfg.svh
`ifndef TDQ_CFG_SVH
`define TDQ_CFG_SVH
// Register byte offsets
`define TDQ_OFF_MASTER_CFG 12'h000
`define TDQ_OFF_DMA_STATUS 12'h040
`define TDQ_OFF_PEND_BASE_LO 12'h800
`define TDQ_OFF_PEND_BASE_HI 12'h804
`define TDQ_OFF_PEND_END 12'h808
`define TDQ_OFF_PEND_WR_PTR 12'h80C
`define TDQ_OFF_PEND_RD_PTR 12'h810
`define TDQ_OFF_DONE_BASE_LO 12'h830
`define TDQ_OFF_DONE_BASE_HI 12'h834
`define TDQ_OFF_DONE_END 12'h838
`define TDQ_OFF_DONE_RD_PTR 12'h83C
`define TDQ_OFF_DONE_WR_PTR 12'h840
`define TDQ_OFF_QUEUES_CTL 12'h880
// Field positions
`define TDQ_BIT_TX_DMA_ENABLE 0
`define TDQ_BIT_PEND_BURST 0
`define TDQ_BIT_PEND_FLUSH 1
`define TDQ_BIT_PEND_READ 0
`define TDQ_BIT_DONE_WRITE 1
`define TDQ_BIT_DONE_WR_ERR 2
// Reset values
`define TDQ_RST_REG16 16'h0000
`define TDQ_RST_STATUS 3'h0
// Pointer step of one dword, wrap target and low water mark
`define TDQ_PTR_STEP 17'h00004
`define TDQ_PTR_WRAP 16'h0000
`define TDQ_LOW_WATER 4
`endif

// >>> verilog/tdq_pkg.sv
`default_nettype none
package tdq_pkg;
  // Sequencer of the shared host memory port
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_DONE} tdq_state_t;
  // Completion codes carried in done entries
  typedef enum logic [2:0] {
    CODE_PKT = 3'h0, CODE_FIRST = 3'h1, CODE_MID = 3'h2, CODE_LAST = 3'h3,
    CODE_NOT_EN = 3'h4, CODE_DESC = 3'h5, CODE_PCI = 3'h6, CODE_UNDER = 3'h7
  } tdq_code_t;
endpackage : tdq_pkg
`default_nettype wire

// >>> verilog/tdq_top.sv
// Overview of operation
// RULE1: Pending full leaves one slot unused.
// RULE2: Equal pending pointers mean empty, fetch nothing.
// RULE3: Fetch only after transmit DMA enable set.
// RULE4: Fetch at base plus pointer, wrap past end.
// RULE5: Each pending read sets read flag.
// RULE6: Prefetch buffer holds sixteen dword entries.
// RULE7: Burst waits for four entries, then refills.
// RULE8: Burst reads only entries actually queued.
// RULE9: Nothing queued means wait, no error.
// RULE10: After burst, pointer advanced, flag set.
// RULE11: Control bit 0 selects burst or single.
// RULE12: Flush bit discards buffered entries.
// RULE13: Done entry per packet or per buffer.
// RULE14: Bits 0-15 carry descriptor offset.
// RULE15: Bits 16-23 carry channel, others free.
// RULE16: Codes 000-011 report packet or buffer.
// RULE17: Codes 100-111 report the error kinds.
// RULE18: Errors request abort and channel disable.
// RULE19: Device owns done write pointer only.
// RULE20: Equal done pointers mean done empty.
// RULE21: Done pointer steps a dword, wraps.
// RULE22: Done overflow sets error, drops entry.
// RULE23: Pointers and ends compared as byte offsets.
// RULE24: No fetching while flush bit set.
`include "tdq_cfg.svh"
`default_nettype none
module tdq_top #(
  parameter int DEPTH = 16,
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic pend_valid,
  output logic [31:0] pend_data,
  input wire logic pend_ready,
  input wire logic done_valid,
  input wire logic done_dqs,
  input wire logic done_first,
  input wire logic done_last,
  input wire logic [2:0] done_err,
  input wire logic [15:0] done_first_ptr,
  input wire logic [15:0] done_buf_ptr,
  input wire logic [7:0] done_channel,
  output logic done_ready,
  output logic abort_valid,
  output logic [7:0] abort_channel
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int IW = $clog2(DEPTH);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] LWM_C = CW'(`TDQ_LOW_WATER);

  tdq_pkg::tdq_state_t state_reg, state_next;
  logic awready_reg, awready_next, wready_reg, wready_next, bvalid_reg, bvalid_next;
  logic arready_reg, arready_next, rvalid_reg, rvalid_next, aw_full_reg, aw_full_next;
  logic w_full_reg, w_full_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic cfg_reg, cfg_next;
  logic [2:0] stat_reg, stat_next, stat_set, stat_clr;
  logic [15:0] pbase_lo_reg, pbase_lo_next, pbase_hi_reg, pbase_hi_next;
  logic [15:0] pend_end_reg, pend_end_next, pwp_reg, pwp_next, prp_reg, prp_next;
  logic [15:0] dbase_lo_reg, dbase_lo_next, dbase_hi_reg, dbase_hi_next;
  logic [15:0] done_end_reg, done_end_next, drp_reg, drp_next, dwp_reg, dwp_next;
  logic [15:0] ctl_reg, ctl_next;
  logic mem_req_reg, mem_req_next, mem_we_reg, mem_we_next;
  logic [31:0] mem_addr_reg, mem_addr_next, mem_wdata_reg, mem_wdata_next;
  logic pv_reg, pv_next, done_ready_reg, done_ready_next, abort_reg, abort_next;
  logic [31:0] pdata_reg, pdata_next;
  logic [7:0] abch_reg, abch_next;
  logic [CW-1:0] cnt_reg, cnt_next, remain_reg, remain_next, occ;
  logic [IW-1:0] wr_idx_reg, wr_idx_next, rd_idx_reg, rd_idx_next;
  logic [31:0] fifo_mem [DEPTH];
  logic push;
  logic [15:0] prp_step, dwp_step;
  logic pend_empty, done_full, burst, flush, enable;
  logic [2:0] code;
  logic [31:0] entry;

  // One dword step, wrapping once the step passes the end offset
  function automatic logic [15:0] ptr_step(input logic [15:0] p, input logic [15:0] e);
    logic [16:0] s;
    s = {1'b0, p} + `TDQ_PTR_STEP;
    // RULE23: same byte units
    return (s > {1'b0, e}) ? `TDQ_PTR_WRAP : s[15:0];
  endfunction : ptr_step

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] wmerge(input logic [15:0] o, input logic [31:0] d,
                                         input logic [3:0] b);
    return {b[1] ? d[15:8] : o[15:8], b[0] ? d[7:0] : o[7:0]};
  endfunction : wmerge

  // Queue state seen by the sequencer
  always_comb begin
    prp_step = ptr_step(prp_reg, pend_end_reg);
    dwp_step = ptr_step(dwp_reg, done_end_reg);
    // RULE2: equal means empty
    pend_empty = (pwp_reg == prp_reg);
    // RULE1: one slot kept free
    // RULE20: read equal to write is empty, one ahead is full
    done_full = (dwp_step == drp_reg);
    burst = ctl_reg[`TDQ_BIT_PEND_BURST];
    flush = ctl_reg[`TDQ_BIT_PEND_FLUSH];
    enable = cfg_reg;
    occ = cnt_reg + CW'(pv_reg);
  end

  // Done entry assembly; unused bits are driven low
  always_comb begin
    // RULE16: completion codes
    if (done_err != 3'h0) begin
      // RULE17: error codes pass through
      code = done_err;
    end else if (!done_dqs) begin
      code = tdq_pkg::CODE_PKT;
    end else if (done_first) begin
      code = tdq_pkg::CODE_FIRST;
    end else if (done_last) begin
      code = tdq_pkg::CODE_LAST;
    end else begin
      code = tdq_pkg::CODE_MID;
    end
    // RULE13: per packet or buffer
    // RULE14: offset by select
    // RULE15: channel in 16-23
    entry = {3'h0, code, 2'h0, done_channel, done_dqs ? done_buf_ptr : done_first_ptr};
  end

  // Bus slave, registers, prefetch buffer and memory sequencer
  always_comb begin
    {awready_next, wready_next, bvalid_next, bresp_next} =
      {awready_reg, wready_reg, bvalid_reg, bresp_reg};
    {arready_next, rvalid_next, rresp_next, rdata_next} =
      {arready_reg, rvalid_reg, rresp_reg, rdata_reg};
    {aw_full_next, w_full_next, awaddr_next, wdata_next, wstrb_next} =
      {aw_full_reg, w_full_reg, awaddr_reg, wdata_reg, wstrb_reg};
    {cfg_next, pbase_lo_next, pbase_hi_next, pend_end_next, pwp_next, prp_next} =
      {cfg_reg, pbase_lo_reg, pbase_hi_reg, pend_end_reg, pwp_reg, prp_reg};
    {dbase_lo_next, dbase_hi_next, done_end_next, drp_next, dwp_next, ctl_next} =
      {dbase_lo_reg, dbase_hi_reg, done_end_reg, drp_reg, dwp_reg, ctl_reg};
    {state_next, mem_req_next, mem_we_next, mem_addr_next, mem_wdata_next} =
      {state_reg, mem_req_reg, mem_we_reg, mem_addr_reg, mem_wdata_reg};
    {pv_next, pdata_next, cnt_next, remain_next, wr_idx_next, rd_idx_next} =
      {pv_reg, pdata_reg, cnt_reg, remain_reg, wr_idx_reg, rd_idx_reg};
    done_ready_next = 1'b0;
    abort_next = 1'b0;
    abch_next = abch_reg;
    stat_set = 3'h0;
    stat_clr = 3'h0;
    push = 1'b0;
    // Address and data are latched separately, in either order
    if (s_axi_awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_full_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (aw_full_reg && w_full_reg && !bvalid_reg) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = 2'h0;
      case (awaddr_reg)
        `TDQ_OFF_MASTER_CFG: if (wstrb_reg[0]) cfg_next = wdata_reg[`TDQ_BIT_TX_DMA_ENABLE];
        `TDQ_OFF_DMA_STATUS: stat_clr = wstrb_reg[0] ? wdata_reg[2:0] : 3'h0;
        `TDQ_OFF_PEND_BASE_LO: pbase_lo_next = wmerge(pbase_lo_reg, wdata_reg, wstrb_reg);
        `TDQ_OFF_PEND_BASE_HI: pbase_hi_next = wmerge(pbase_hi_reg, wdata_reg, wstrb_reg);
        `TDQ_OFF_PEND_END: pend_end_next = wmerge(pend_end_reg, wdata_reg, wstrb_reg);
        `TDQ_OFF_PEND_WR_PTR: pwp_next = wmerge(pwp_reg, wdata_reg, wstrb_reg);
        `TDQ_OFF_PEND_RD_PTR: prp_next = wmerge(prp_reg, wdata_reg, wstrb_reg);
        `TDQ_OFF_DONE_BASE_LO: dbase_lo_next = wmerge(dbase_lo_reg, wdata_reg, wstrb_reg);
        `TDQ_OFF_DONE_BASE_HI: dbase_hi_next = wmerge(dbase_hi_reg, wdata_reg, wstrb_reg);
        `TDQ_OFF_DONE_END: done_end_next = wmerge(done_end_reg, wdata_reg, wstrb_reg);
        // RULE19: host moves done read pointer
        `TDQ_OFF_DONE_RD_PTR: drp_next = wmerge(drp_reg, wdata_reg, wstrb_reg);
        `TDQ_OFF_DONE_WR_PTR: dwp_next = wmerge(dwp_reg, wdata_reg, wstrb_reg);
        `TDQ_OFF_QUEUES_CTL: ctl_next = wmerge(ctl_reg, wdata_reg, wstrb_reg);
        default: bresp_next = 2'h2; // Unmapped writes answer SLVERR
      endcase
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // Reads answer one cycle after acceptance
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = 2'h0;
      rdata_next = 32'h0000_0000;
      case (s_axi_araddr)
        `TDQ_OFF_MASTER_CFG: rdata_next[`TDQ_BIT_TX_DMA_ENABLE] = cfg_reg;
        `TDQ_OFF_DMA_STATUS: rdata_next[2:0] = stat_reg;
        `TDQ_OFF_PEND_BASE_LO: rdata_next[15:0] = pbase_lo_reg;
        `TDQ_OFF_PEND_BASE_HI: rdata_next[15:0] = pbase_hi_reg;
        `TDQ_OFF_PEND_END: rdata_next[15:0] = pend_end_reg;
        `TDQ_OFF_PEND_WR_PTR: rdata_next[15:0] = pwp_reg;
        `TDQ_OFF_PEND_RD_PTR: rdata_next[15:0] = prp_reg;
        `TDQ_OFF_DONE_BASE_LO: rdata_next[15:0] = dbase_lo_reg;
        `TDQ_OFF_DONE_BASE_HI: rdata_next[15:0] = dbase_hi_reg;
        `TDQ_OFF_DONE_END: rdata_next[15:0] = done_end_reg;
        `TDQ_OFF_DONE_RD_PTR: rdata_next[15:0] = drp_reg;
        `TDQ_OFF_DONE_WR_PTR: rdata_next[15:0] = dwp_reg;
        `TDQ_OFF_QUEUES_CTL: rdata_next[15:0] = ctl_reg;
        default: rresp_next = 2'h2;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
    awready_next = !aw_full_next && !bvalid_next;
    wready_next = !w_full_next && !bvalid_next;
    // Output stage of the prefetch buffer
    if ((!pv_reg || pend_ready) && cnt_reg != '0) begin
      pv_next = 1'b1;
      pdata_next = fifo_mem[rd_idx_reg];
      rd_idx_next = IW'((32'(rd_idx_reg) + 1) % DEPTH);
      cnt_next = cnt_reg - CW'(1);
    end else if (pend_ready) begin
      pv_next = 1'b0;
    end
    case (state_reg)
      tdq_pkg::ST_IDLE: begin
        // Done writes win over prefetch; a fetch can wait, a completion cannot
        if (enable && done_valid && !done_ready_reg) begin
          if (done_full) begin
            // RULE22: overflow drops entry
            stat_set[`TDQ_BIT_DONE_WR_ERR] = 1'b1;
            done_ready_next = 1'b1;
          end else begin
            mem_req_next = 1'b1;
            mem_we_next = 1'b1;
            mem_addr_next = {dbase_hi_reg, dbase_lo_reg} + {16'h0000, dwp_reg};
            mem_wdata_next = entry;
            state_next = tdq_pkg::ST_DONE;
          end
        // RULE3: enable gates fetch
        // RULE24: no fetch during flush
        // RULE9: empty queue just waits
        end else if (enable && !flush && !pend_empty &&
                     // RULE7: low water wait
                     // RULE11: burst or single
                     (burst ? (occ <= LWM_C) : (occ < DEPTH_C))) begin
          // RULE6: never past depth
          // RULE8: bounded by free slots; queue end checked per beat
          remain_next = burst ? DEPTH_C - occ : CW'(1);
          mem_req_next = 1'b1;
          mem_we_next = 1'b0;
          // RULE4: base plus read pointer
          mem_addr_next = {pbase_hi_reg, pbase_lo_reg} + {16'h0000, prp_reg};
          state_next = tdq_pkg::ST_FETCH;
        end
      end
      tdq_pkg::ST_FETCH: begin
        if (mem_ack) begin
          mem_req_next = 1'b0;
          // RULE12: flush drops arrivals
          push = !flush;
          // RULE4: advance and wrap
          // RULE10: pointer past fetched
          prp_next = prp_step;
          // RULE5: flag per read
          stat_set[`TDQ_BIT_PEND_READ] = 1'b1;
          remain_next = remain_reg - CW'(1);
          // RULE8: stop once queue empties
          if (remain_reg > CW'(1) && prp_step != pwp_reg && !flush && enable) begin
            mem_req_next = 1'b1;
            mem_addr_next = {pbase_hi_reg, pbase_lo_reg} + {16'h0000, prp_step};
          end else begin
            state_next = tdq_pkg::ST_IDLE;
          end
        end
      end
      tdq_pkg::ST_DONE: begin
        if (mem_ack) begin
          mem_req_next = 1'b0;
          mem_we_next = 1'b0;
          // RULE21: done pointer step
          dwp_next = dwp_step;
          stat_set[`TDQ_BIT_DONE_WRITE] = 1'b1;
          done_ready_next = 1'b1;
          // RULE18: abort on error
          abort_next = mem_wdata_reg[28];
          abch_next = mem_wdata_reg[23:16];
          state_next = tdq_pkg::ST_IDLE;
        end
      end
      default: state_next = tdq_pkg::ST_IDLE;
    endcase
    if (push) begin
      wr_idx_next = IW'((32'(wr_idx_reg) + 1) % DEPTH);
      cnt_next = cnt_next + CW'(1);
    end
    // RULE12: flush empties buffer
    if (flush) begin
      {pv_next, cnt_next, wr_idx_next, rd_idx_next} = '0;
    end
    // Set beats clear so no event is lost
    stat_next = (stat_reg & ~stat_clr) | stat_set;
  end

  // Registered state; ce low freezes everything except the synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= tdq_pkg::ST_IDLE;
      {awready_reg, wready_reg, arready_reg} <= 3'h7;
      {bvalid_reg, rvalid_reg, aw_full_reg, w_full_reg} <= 4'h0;
      {bresp_reg, rresp_reg, awaddr_reg, wdata_reg, wstrb_reg, rdata_reg} <= '0;
      cfg_reg <= 1'b0;
      stat_reg <= `TDQ_RST_STATUS;
      {pbase_lo_reg, pbase_hi_reg, pend_end_reg} <= {3{`TDQ_RST_REG16}};
      {pwp_reg, prp_reg, ctl_reg} <= {3{`TDQ_RST_REG16}};
      {dbase_lo_reg, dbase_hi_reg, done_end_reg} <= {3{`TDQ_RST_REG16}};
      {drp_reg, dwp_reg} <= {2{`TDQ_RST_REG16}};
      {mem_req_reg, mem_we_reg, mem_addr_reg, mem_wdata_reg} <= '0;
      {pv_reg, pdata_reg, cnt_reg, remain_reg, wr_idx_reg, rd_idx_reg} <= '0;
      {done_ready_reg, abort_reg, abch_reg} <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      {awready_reg, wready_reg, arready_reg} <= {awready_next, wready_next, arready_next};
      {bvalid_reg, rvalid_reg, aw_full_reg, w_full_reg} <=
        {bvalid_next, rvalid_next, aw_full_next, w_full_next};
      {bresp_reg, rresp_reg, awaddr_reg, wdata_reg, wstrb_reg, rdata_reg} <=
        {bresp_next, rresp_next, awaddr_next, wdata_next, wstrb_next, rdata_next};
      cfg_reg <= cfg_next;
      stat_reg <= stat_next;
      {pbase_lo_reg, pbase_hi_reg, pend_end_reg} <= {pbase_lo_next, pbase_hi_next, pend_end_next};
      {pwp_reg, prp_reg, ctl_reg} <= {pwp_next, prp_next, ctl_next};
      {dbase_lo_reg, dbase_hi_reg, done_end_reg} <= {dbase_lo_next, dbase_hi_next, done_end_next};
      {drp_reg, dwp_reg} <= {drp_next, dwp_next};
      {mem_req_reg, mem_we_reg, mem_addr_reg, mem_wdata_reg} <=
        {mem_req_next, mem_we_next, mem_addr_next, mem_wdata_next};
      {pv_reg, pdata_reg, cnt_reg, remain_reg, wr_idx_reg, rd_idx_reg} <=
        {pv_next, pdata_next, cnt_next, remain_next, wr_idx_next, rd_idx_next};
      {done_ready_reg, abort_reg, abch_reg} <= {done_ready_next, abort_next, abch_next};
    end
  end

  // Buffer storage, no reset needed since count guards it
  always_ff @(posedge aclk) begin
    if (ce && push) begin
      fifo_mem[wr_idx_reg] <= mem_rdata;
    end
  end

  assign {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp} =
    {awready_reg, wready_reg, bvalid_reg, bresp_reg};
  assign {s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata} =
    {arready_reg, rvalid_reg, rresp_reg, rdata_reg};
  assign {mem_req, mem_we, mem_addr, mem_wdata} =
    {mem_req_reg, mem_we_reg, mem_addr_reg, mem_wdata_reg};
  assign {pend_valid, pend_data, done_ready} = {pv_reg, pdata_reg, done_ready_reg};
  assign {abort_valid, abort_channel} = {abort_reg, abch_reg};

  empty_no_fetch_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // RULE2
    $rose(mem_req_reg) && !mem_we_reg |-> !$past(pend_empty)) else $error("fetch from empty");
  enable_gate_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // RULE3
    $rose(mem_req_reg) |-> $past(enable)) else $error("access while disabled");
  read_ptr_step_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // RULE4
    state_reg == tdq_pkg::ST_FETCH && mem_ack |=> prp_reg == $past(prp_step))
    else $error("read pointer step wrong");
  read_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // RULE5
    state_reg == tdq_pkg::ST_FETCH && mem_ack |=> stat_reg[`TDQ_BIT_PEND_READ])
    else $error("read flag not set");
  depth_bound_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // RULE6
    occ <= DEPTH_C) else $error("buffer overfilled");
  burst_water_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // RULE7
    $rose(mem_req_reg) && !mem_we_reg && $past(burst) |-> $past(occ) <= LWM_C)
    else $error("burst above low water");
  flush_clears_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // RULE12
    flush |=> cnt_reg == '0 && !pv_reg) else $error("flush left entries");
  flush_no_fetch_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // RULE24
    flush && state_reg == tdq_pkg::ST_IDLE |=> state_reg != tdq_pkg::ST_FETCH)
    else $error("fetch during flush");
  done_overflow_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // RULE22
    state_reg == tdq_pkg::ST_IDLE && enable && done_valid && !done_ready_reg && done_full
    |=> stat_reg[`TDQ_BIT_DONE_WR_ERR] && !mem_req_reg && dwp_reg == $past(dwp_reg))
    else $error("overflow not handled");
  abort_error_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // RULE18
    state_reg == tdq_pkg::ST_DONE && mem_ack |=> abort_valid == $past(mem_wdata_reg[28]))
    else $error("abort request wrong");
endmodule : tdq_top
`default_nettype wire

// >>> sim/tdq_host_mem.sv
`default_nettype none
module tdq_host_mem #(
  parameter int LAT = 2
) (
  input wire logic aclk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  int wc = 0;
  logic [31:0] wa = 32'h0;
  logic [31:0] wd = 32'h0;
  initial mem_ack = 1'h0;
  initial mem_rdata = 32'h0;
  // Host memory answers LAT cycles after it first sees a request; idle data toggles so stale reads show
  always @(posedge aclk) begin
    mem_ack <= 1'h0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack && n < LAT) n <= n + 1;
    else if (mem_req && !mem_ack) begin
      n <= 0;
      mem_ack <= 1'h1;
      if (mem_we) begin
        wa <= mem_addr;
        wd <= mem_wdata;
        wc <= wc + 1;
      end else mem_rdata <= mem_addr ^ 32'hA5A50000;
    end
  end
endmodule : tdq_host_mem
`default_nettype wire

// >>> sim/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PAT = 32'hA5A50000;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, pend_ready = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic done_valid = 1'h0, done_dqs = 1'h0, done_first = 1'h1, done_last = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] done_err = 3'h0;
  logic [15:0] done_first_ptr = 16'h0, done_buf_ptr = 16'h0;
  logic [7:0] done_channel = 8'h0, abort_channel, ab_ch = 8'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic mem_req, mem_we, mem_ack, pend_valid, done_ready, abort_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, mem_addr, mem_wdata, mem_rdata, pend_data, v;
  logic [31:0] q[$];
  int bad_count = 0;
  int checked = 0;
  tdq_top DUT (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata, .pend_valid, .pend_data, .pend_ready, .done_valid, .done_dqs, .done_first,
    .done_last, .done_err, .done_first_ptr, .done_buf_ptr, .done_channel, .done_ready,
    .abort_valid, .abort_channel);
  tdq_host_mem #(.LAT(2)) HM (.aclk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata);
  // 200 MHz clock
  always #2.5 aclk = ~aclk;
  // Collect prefetched entries and abort requests
  always @(posedge aclk) begin
    if (pend_valid && pend_ready) q.push_back(pend_data);
    if (abort_valid) ab_ch <= abort_channel;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // Write holds each channel until its own ready, then waits for the response
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : axw
  task automatic axr(input logic [11:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : axr
  // Completion held until consumed; the unused pointer differs to expose a wrong pick
  task automatic dreq(input logic d, input logic [15:0] p, input logic [7:0] c,
                      input logic [2:0] e);
    @(posedge aclk);
    done_dqs <= d;
    done_first_ptr <= d ? ~p : p;
    done_buf_ptr <= d ? p : ~p;
    done_channel <= c;
    done_err <= e;
    done_valid <= 1'h1;
    do @(posedge aclk); while (!done_ready);
    done_valid <= 1'h0;
  endtask : dreq
  task automatic waitq(input int n);
    while (q.size() < n) @(posedge aclk);
  endtask : waitq
  initial begin
    #50000;
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    axr(12'h880, v);
    chk(v, 32'h0);
    axr(12'hFFC, v);
    chk({30'h0, rsp}, 32'h2);
    axw(12'hFF8, 32'h1);
    chk({30'h0, rsp}, 32'h2);
    axw(12'h800, 32'h1000);
    axw(12'h808, 32'h1C);
    axw(12'h80C, 32'h8);
    repeat (20) @(posedge aclk);
    chk(32'(q.size()), 32'h0);
    axw(12'h000, 32'h1);
    waitq(2);
    chk(q[0], 32'h1000 ^ PAT);
    chk(q[1], 32'h1004 ^ PAT);
    axr(12'h810, v);
    chk(v, 32'h8);
    axr(12'h040, v);
    chk({31'h0, v[0]}, 32'h1);
    $display("single fetch test done");
    axw(12'h880, 32'h1);
    // host leaves the two slots before the read pointer
    axw(12'h80C, 32'h0);
    waitq(8);
    repeat (20) @(posedge aclk);
    chk(32'(q.size()), 32'h8);
    chk(q[7], 32'h101C ^ PAT);
    axr(12'h810, v);
    chk(v, 32'h0);
    $display("burst wrap test done");
    axw(12'h880, 32'h3);
    axw(12'h040, 32'h1);
    axw(12'h80C, 32'h8);
    repeat (20) @(posedge aclk);
    chk(32'(q.size()), 32'h8);
    axw(12'h880, 32'h1);
    waitq(10);
    chk(q[9], 32'h1004 ^ PAT);
    axr(12'h040, v);
    chk({31'h0, v[0]}, 32'h1);
    $display("flush test done");
    // Consumer stalls: a burst may fill the buffer but never overfill it
    axw(12'h808, 32'hFC);
    pend_ready <= 1'h0;
    axw(12'h80C, 32'h58);
    repeat (100) @(posedge aclk);
    axr(12'h810, v);
    chk(v, 32'h48);
    // Flush with a full buffer, then refill from where the pointer stands
    axw(12'h880, 32'h3);
    pend_ready <= 1'h1;
    axw(12'h880, 32'h1);
    waitq(14);
    chk(q[10], 32'h1048 ^ PAT);
    axr(12'h810, v);
    chk(v, 32'h58);
    $display("fill and flush test done");
    axw(12'h830, 32'h2000);
    axw(12'h838, 32'h8);
    // equal done pointers: queue empty, room to write
    dreq(1'h1, 16'h0040, 8'hFF, 3'h0);
    chk(HM.wa, 32'h2000);
    chk(HM.wd, 32'h04FF0040);
    dreq(1'h0, 16'h0080, 8'h03, 3'h7);
    chk(HM.wd, 32'h1C030080);
    // Abort channel is captured by a non-blocking update; let it settle
    @(posedge aclk);
    chk({24'h0, ab_ch}, 32'h3);
    dreq(1'h1, 16'h0044, 8'h01, 3'h0);
    chk(32'(HM.wc), 32'h2);
    axr(12'h040, v);
    chk({31'h0, v[2]}, 32'h1);
    axr(12'h840, v);
    chk(v, 32'h8);
    // only the host moves the done read pointer
    axw(12'h83C, 32'h4);
    done_first <= 1'h0;
    done_last <= 1'h1;
    dreq(1'h1, 16'h0044, 8'h01, 3'h0);
    chk(HM.wa, 32'h2008);
    chk(HM.wd, 32'h0C010044);
    axr(12'h840, v);
    chk(v, 32'h0);
    chk({24'h0, ab_ch}, 32'h3);
    $display("done queue test done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
